// ==== core/cpps_level_filter.v ====
// Pilot level classifier with consecutive-sample debounce
`timescale 1ns/1ps
`default_nettype none
`include "cpps_defs.vh"
module cpps_level_filter #(
   parameter MATCH = `CPPS_MATCH_COUNT
) (
   input wire clk,
   input wire rst,
   input wire sampleValid,
   input wire [15:0] sample,
   input wire [15:0] thrAB,
   input wire [15:0] thrBC,
   input wire [15:0] thrCD,
   input wire [15:0] thrDE,
   output reg [2:0] level
);
   reg [2:0] rawLevel;
   reg [2:0] candidate;
   reg [3:0] matchCount;

   // Classify against thresholds, highest voltage first
   always @* begin
      if (sample >= thrAB)
         rawLevel = `CPPS_ST_A;
      else if (sample >= thrBC)
         rawLevel = `CPPS_ST_B;
      else if (sample >= thrCD)
         rawLevel = `CPPS_ST_C;
      else if (sample >= thrDE)
         rawLevel = `CPPS_ST_D;
      else
         rawLevel = `CPPS_ST_E;
   end

   // Accept a level only after MATCH equal samples in a row
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         candidate <= `CPPS_ST_A;
         matchCount <= 4'h0;
         level <= `CPPS_ST_A;
      end else if (sampleValid) begin
         if (rawLevel != candidate) begin
            candidate <= rawLevel;
            matchCount <= 4'h1;
         end else if (matchCount < MATCH[3:0]) begin
            matchCount <= matchCount + 4'h1;
            if (matchCount + 4'h1 == MATCH[3:0])
               level <= candidate;
         end
      end
   end
endmodule // cpps_level_filter
`default_nettype wire

// ==== core/cpps_pilot_sequencer.v ====
// Control pilot PWM generator, ADC trigger and connection state tracker
`timescale 1ns/1ps
`default_nettype none
`include "cpps_defs.vh"
module cpps_pilot_sequencer #(
   parameter CNT_W = 16,
   parameter PERIOD_TICKS = `CPPS_PERIOD_TICKS,
   parameter MATCH = `CPPS_MATCH_COUNT
) (
   input wire clk,
   input wire rst,
   input wire supplyFault,
   input wire chargeAllow,
   input wire [6:0] dutyPct,
   input wire [1:0] trigSelect,
   input wire extTrigA,
   input wire extTrigB,
   input wire adcDone,
   input wire [15:0] adcResult,
   input wire [15:0] thrAB,
   input wire [15:0] thrBC,
   input wire [15:0] thrCD,
   input wire [15:0] thrDE,
   output reg pilotPwmDrive,
   output reg midOnAdcTrigger,
   output wire adcConvStart,
   output wire adcSingleEnded,
   output reg [1:0] driveMode,
   output wire [2:0] pilotState,
   output reg charging,
   output reg highLevelOffer,
   output reg dutyRejected
);
   // ****************************************
   // Derived counter constants
   // ****************************************
   localparam [31:0] HALF = PERIOD_TICKS / 2;
   localparam [31:0] START_WIDE = 32'h0 - HALF;
   localparam [31:0] END_WIDE = HALF - 32'h1;
   // Counter is narrower than the integer maths; keep only the low bits
   localparam [CNT_W-1:0] START_VAL = START_WIDE[CNT_W-1:0];
   localparam [CNT_W-1:0] PERIOD_END_VAL = END_WIDE[CNT_W-1:0];
   localparam [CNT_W-1:0] TRIGGER_VAL = {CNT_W{1'b0}};

   reg [CNT_W-1:0] pwmCount;
   reg [CNT_W-1:0] riseCompareValue;
   reg [CNT_W-1:0] fallCompareValue;
   reg [CNT_W-1:0] riseShadow;
   reg [CNT_W-1:0] fallShadow;
   reg [1:0] modeShadow;
   reg [6:0] dutyUsed;
   reg [CNT_W-1:0] halfOn;
   reg [31:0] halfOnWide;
   reg [1:0] next_mode;
   reg next_charging;
   wire [2:0] level;
   wire periodEnd;
   wire dutyOk;

   // ****************************************
   // Connection state filtering
   // ****************************************
   cpps_level_filter #(
      .MATCH(MATCH)
   ) uLevel (
      .clk(clk),
      .rst(rst),
      .sampleValid(adcDone),
      .sample(adcResult),
      .thrAB(thrAB),
      .thrBC(thrBC),
      .thrCD(thrCD),
      .thrDE(thrDE),
      .level(level)
   );
   // Every result is used whatever the drive mode
   assign pilotState = level;
   // Converter always runs single-ended, 16-bit results
   assign adcSingleEnded = 1'b1;

   // ****************************************
   // Duty to compare value conversion
   // ****************************************
   // Out-of-range duty is refused and the old setting kept
   assign dutyOk = (dutyPct >= `CPPS_DUTY_MIN_PCT) && (dutyPct <= `CPPS_DUTY_MAX_PCT);

   // Half on-time in ticks, symmetric about zero
   always @* begin
      halfOnWide = (PERIOD_TICKS * dutyUsed) / 200;
      halfOn = halfOnWide[CNT_W-1:0];
   end

   // Remember the last accepted duty; rejected values flag an error
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         dutyUsed <= 7'h05;
         dutyRejected <= 1'b0;
      end else begin
         dutyRejected <= !dutyOk;
         if (dutyOk)
            dutyUsed <= dutyPct;
      end
   end

   // Shadow compare values, only rise and fall follow the duty
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         riseShadow <= {CNT_W{1'b0}};
         fallShadow <= {CNT_W{1'b0}};
      end else begin
         riseShadow <= {CNT_W{1'b0}} - halfOn;
         fallShadow <= halfOn;
      end
   end

   // ****************************************
   // Connection sequencing
   // ****************************************
   // Drive mode follows fault, vehicle level and supply permission
   always @* begin
      next_mode = `CPPS_MODE_HIGH;
      next_charging = 1'b0;
      if (supplyFault) begin
         next_mode = `CPPS_MODE_LOW;
      end else begin
         case (level)
            `CPPS_ST_A: begin
               next_mode = `CPPS_MODE_HIGH;
            end
            `CPPS_ST_B: begin
               // Vehicle present but not ready, or charge ended
               next_mode = `CPPS_MODE_HIGH;
            end
            `CPPS_ST_C: begin
               // Ready vehicle; pulses only if supply allows
               if (chargeAllow) begin
                  next_mode = `CPPS_MODE_PWM;
                  next_charging = 1'b1;
               end
            end
            `CPPS_ST_D: begin
               next_mode = `CPPS_MODE_HIGH;
            end
            default: begin
               // Error level is not acted on beyond holding idle
               next_mode = `CPPS_MODE_HIGH;
            end
         endcase
      end
   end

   // Requested mode and charging status registers
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         modeShadow <= `CPPS_MODE_HIGH;
         charging <= 1'b0;
      end else begin
         modeShadow <= next_mode;
         charging <= next_charging;
      end
   end

   // ****************************************
   // Centre-aligned counter
   // ****************************************
   assign periodEnd = (pwmCount == PERIOD_END_VAL);

   // Count up through zero, reload at period end
   always @(posedge clk or posedge rst) begin
      if (rst)
         pwmCount <= START_VAL;
      else if (periodEnd)
         pwmCount <= START_VAL;
      else
         pwmCount <= pwmCount + {{(CNT_W-1){1'b0}}, 1'b1};
   end

   // Load mode and compares only at period start; avoids runt pulses
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         driveMode <= `CPPS_MODE_HIGH;
         riseCompareValue <= {CNT_W{1'b0}};
         fallCompareValue <= {CNT_W{1'b0}};
         highLevelOffer <= 1'b0;
      end else if (periodEnd) begin
         driveMode <= modeShadow;
         riseCompareValue <= riseShadow;
         fallCompareValue <= fallShadow;
         // Five percent pulses tell the vehicle the modem is on offer
         highLevelOffer <= (modeShadow == `CPPS_MODE_PWM) &&
            (dutyUsed == `CPPS_DUTY_HLS_PCT);
      end
   end

   // ****************************************
   // Pilot output and trigger
   // ****************************************
   // Vehicle decodes frequency and duty of this drive
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         pilotPwmDrive <= 1'b1;
      end else begin
         case (driveMode)
            `CPPS_MODE_HIGH: pilotPwmDrive <= 1'b1;
            `CPPS_MODE_LOW: pilotPwmDrive <= 1'b0;
            `CPPS_MODE_PWM: begin
               if (pwmCount == riseCompareValue)
                  pilotPwmDrive <= 1'b1;
               else if (pwmCount == fallCompareValue)
                  pilotPwmDrive <= 1'b0;
               // Low at period start so a switch from high mode gives no long pulse
               else if (periodEnd || (pwmCount == START_VAL))
                  pilotPwmDrive <= 1'b0;
            end
            default: pilotPwmDrive <= 1'b1;
         endcase
      end
   end

   // One-cycle pulse on zero crossing, every period in any mode
   always @(posedge clk or posedge rst) begin
      if (rst)
         midOnAdcTrigger <= 1'b0;
      else
         midOnAdcTrigger <= (pwmCount == TRIGGER_VAL);
   end

   // Trigger route mux into the converter start
   assign adcConvStart = (trigSelect == 2'h1) ? extTrigA :
                         (trigSelect == 2'h2) ? extTrigB : midOnAdcTrigger;
endmodule // cpps_pilot_sequencer
`default_nettype wire

// ==== include/cpps_defs.vh ====
// Constants for the control pilot PWM sequencer
`ifndef CPPS_DEFS_VH
`define CPPS_DEFS_VH

// ****************************************
// Timing
// ****************************************
`define CPPS_CLK_HZ 25000000
`define CPPS_PWM_HZ 1000
`define CPPS_PERIOD_TICKS (`CPPS_CLK_HZ / `CPPS_PWM_HZ)
`define CPPS_HALF_TICKS (`CPPS_PERIOD_TICKS / 2)
`define CPPS_DUTY_MIN_PCT 7'h03
`define CPPS_DUTY_MAX_PCT 7'h61
`define CPPS_DUTY_HLS_PCT 7'h05
`define CPPS_MATCH_COUNT 4

// ****************************************
// Drive modes
// ****************************************
`define CPPS_MODE_HIGH 2'h0
`define CPPS_MODE_LOW 2'h1
`define CPPS_MODE_PWM 2'h2

// ****************************************
// Connection states
// ****************************************
`define CPPS_ST_A 3'h0
`define CPPS_ST_B 3'h1
`define CPPS_ST_C 3'h2
`define CPPS_ST_D 3'h3
`define CPPS_ST_E 3'h4

// ****************************************
// Reset thresholds, midway between levels
// ****************************************
`define CPPS_THR_AB_RST 16'hD000
`define CPPS_THR_BC_RST 16'hB000
`define CPPS_THR_CD_RST 16'h9000
`define CPPS_THR_DE_RST 16'h7000

`endif

// ==== testbench/cpps_ev_model.sv ====
// Vehicle pilot load and conversion model
`timescale 1ns/1ps
`default_nettype none
module cpps_ev_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic pilotPwmDrive,
   input wire logic adcConvStart,
   input wire logic [1:0] evLoad,
   output logic adcDone,
   output logic [15:0] adcResult
);
   logic [2:0] pipe;
   logic [15:0] lvl;
   logic [15:0] held;
   // Vehicle resistors pull the positive level down
   assign lvl = !pilotPwmDrive ? 16'h1000 : evLoad == 2'h0 ? 16'hE000 :
      evLoad == 2'h1 ? 16'hC000 : evLoad == 2'h2 ? 16'hA000 : 16'h8000;
   // Level held at the trigger, as a sample-and-hold would; short pulses end before done
   // Four cycle conversion; result toggles when not valid so it is never stale
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         pipe <= 3'h0;
         held <= 16'h0000;
         adcDone <= 1'b0;
         adcResult <= 16'h0000;
      end else begin
         pipe <= {pipe[1:0], adcConvStart};
         held <= adcConvStart ? lvl : held;
         adcDone <= pipe[2];
         adcResult <= pipe[2] ? held : ~adcResult;
      end
   end
endmodule // cpps_ev_model
`default_nettype wire

// ==== testbench/cpps_pilot_chk.sv ====
// Port assertions for the control pilot sequencer
`timescale 1ns/1ps
`default_nettype none
`include "cpps_defs.vh"
module cpps_pilot_chk #(
   parameter PERIOD_TICKS = `CPPS_PERIOD_TICKS
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic supplyFault,
   input wire logic [6:0] dutyPct,
   input wire logic [1:0] trigSelect,
   input wire logic extTrigA,
   input wire logic extTrigB,
   input wire logic adcDone,
   input wire logic pilotPwmDrive,
   input wire logic midOnAdcTrigger,
   input wire logic adcConvStart,
   input wire logic adcSingleEnded,
   input wire logic [1:0] driveMode,
   input wire logic [2:0] pilotState,
   input wire logic charging,
   input wire logic highLevelOffer,
   input wire logic dutyRejected
);
   // ****
   // Trigger spacing counter
   // ****
   int gap;
   // Zero means no trigger seen since reset, so the first gap is not judged
   always @(posedge clk or posedge rst) begin
      if (rst) gap <= 0;
      else if (midOnAdcTrigger) gap <= 1;
      else if (gap != 0) gap <= gap + 1;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence sPulse;
      midOnAdcTrigger ##1 !midOnAdcTrigger;
   endsequence
   AST_TRIG_PULSE: assert property ($rose(midOnAdcTrigger) |-> sPulse)
      else $error("trigger longer than one cycle");
   AST_TRIG_GAP: assert property (midOnAdcTrigger && gap != 0 |-> gap == PERIOD_TICKS)
      else $error("trigger spacing is not one period");
   AST_HIGH_HOLD: assert property (driveMode == `CPPS_MODE_HIGH &&
      $past(driveMode, 2) == `CPPS_MODE_HIGH |-> pilotPwmDrive)
      else $error("drive not high in high mode");
   AST_LOW_HOLD: assert property (driveMode == `CPPS_MODE_LOW &&
      $past(driveMode, 2) == `CPPS_MODE_LOW |-> !pilotPwmDrive)
      else $error("drive not low in low mode");
   AST_CENTRE: assert property (driveMode == `CPPS_MODE_PWM &&
      midOnAdcTrigger |-> pilotPwmDrive)
      else $error("trigger outside on-time");
   AST_MUX: assert property (adcConvStart == (trigSelect == 2'h1 ? extTrigA :
      trigSelect == 2'h2 ? extTrigB : midOnAdcTrigger))
      else $error("conversion start wrongly routed");
   AST_SINGLE: assert property (adcSingleEnded)
      else $error("conversion not single ended");
   AST_STATE_SRC: assert property ($changed(pilotState) |-> $past(adcDone))
      else $error("state moved without a sample");
   AST_NO_CHARGE: assert property ((pilotState != `CPPS_ST_C &&
      $past(pilotState) != `CPPS_ST_C) || (supplyFault && $past(supplyFault)) |-> !charging)
      else $error("charging outside state C");
   AST_REJECT: assert property (dutyRejected == $past(dutyPct < 7'h03 || dutyPct > 7'h61))
      else $error("duty refusal flag wrong");
   AST_OFFER: assert property (highLevelOffer |-> driveMode == `CPPS_MODE_PWM)
      else $error("offer without pulses");
endmodule // cpps_pilot_chk
bind cpps_pilot_sequencer cpps_pilot_chk #(.PERIOD_TICKS(PERIOD_TICKS)) u_chk (
   .clk(clk), .rst(rst), .supplyFault(supplyFault), .dutyPct(dutyPct),
   .trigSelect(trigSelect), .extTrigA(extTrigA), .extTrigB(extTrigB), .adcDone(adcDone),
   .pilotPwmDrive(pilotPwmDrive), .midOnAdcTrigger(midOnAdcTrigger),
   .adcConvStart(adcConvStart), .adcSingleEnded(adcSingleEnded), .driveMode(driveMode),
   .pilotState(pilotState), .charging(charging), .highLevelOffer(highLevelOffer),
   .dutyRejected(dutyRejected));
`default_nettype wire

// ==== testbench/testbench.sv ====
// Self-checking bench for the pilot sequencer
`timescale 1ns/1ps
`default_nettype none
`include "cpps_defs.vh"
module testbench;
   logic clk = 0, rst = 1, supplyFault = 0, chargeAllow = 0, extTrigA = 0, extTrigB = 0;
   logic [6:0] dutyPct = 7'h32;
   logic [1:0] trigSelect = 2'h0, evLoad = 2'h0, driveMode;
   logic [15:0] adcResult;
   logic [2:0] pilotState;
   logic pilotPwmDrive, midOnAdcTrigger, adcConvStart, adcSingleEnded, charging;
   logic highLevelOffer, dutyRejected, adcDone;
   int errors = 0, cmp_count = 0, hi, per;
   // Free-running 25 MHz clock
   initial forever #20 clk = ~clk;
   // Short period keeps the run brief
   cpps_pilot_sequencer #(.PERIOD_TICKS(200)) uut (.clk(clk), .rst(rst),
      .supplyFault(supplyFault), .chargeAllow(chargeAllow), .dutyPct(dutyPct),
      .trigSelect(trigSelect), .extTrigA(extTrigA), .extTrigB(extTrigB), .adcDone(adcDone),
      .adcResult(adcResult), .thrAB(`CPPS_THR_AB_RST), .thrBC(`CPPS_THR_BC_RST),
      .thrCD(`CPPS_THR_CD_RST), .thrDE(`CPPS_THR_DE_RST), .pilotPwmDrive(pilotPwmDrive),
      .midOnAdcTrigger(midOnAdcTrigger), .adcConvStart(adcConvStart),
      .adcSingleEnded(adcSingleEnded), .driveMode(driveMode), .pilotState(pilotState),
      .charging(charging), .highLevelOffer(highLevelOffer), .dutyRejected(dutyRejected));
   cpps_ev_model ev (.clk(clk), .rst(rst), .pilotPwmDrive(pilotPwmDrive),
      .adcConvStart(adcConvStart), .evLoad(evLoad), .adcDone(adcDone), .adcResult(adcResult));
   task final_report;
      $display("compares %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   // Bounded wait for a debounced state
   task wait_state(input logic [2:0] s);
      for (int i = 0; i < 4000 && pilotState !== s; i++) @(negedge clk);
      chk(16'(pilotState), 16'(s));
      if (pilotState !== s) final_report;
   endtask
   // High time and period of one pulse, as the vehicle sees it
   task measure;
      hi = 0;
      for (int i = 0; i < 400 && pilotPwmDrive !== 1'b0; i++) @(negedge clk);
      for (int i = 0; i < 400 && pilotPwmDrive !== 1'b1; i++) @(negedge clk);
      for (; hi < 400 && pilotPwmDrive === 1'b1; hi++) @(negedge clk);
      for (per = hi; per < 400 && pilotPwmDrive === 1'b0; per++) @(negedge clk);
   endtask
   task t_charge;
      chk(16'(pilotPwmDrive), 16'h1);
      evLoad = 2'h1;
      wait_state(`CPPS_ST_B);
      cyc(450);
      chk(16'(driveMode), 16'(`CPPS_MODE_HIGH));
      chargeAllow = 1;
      evLoad = 2'h2;
      wait_state(`CPPS_ST_C);
      cyc(450);
      chk(16'(charging), 16'h1);
      chk(16'(driveMode), 16'(`CPPS_MODE_PWM));
      measure;
      chk(16'(hi), 16'd100);
      chk(16'(per), 16'd200);
      $display("charge test done");
   endtask
   task t_duty;
      logic [6:0] d[5] = '{7'h05, 7'h61, 7'h03, 7'h02, 7'h62};
      int e[5] = '{10, 194, 6, 6, 6};
      for (int i = 0; i < 5; i++) begin
         dutyPct = d[i];
         cyc(1);
         chk(16'(dutyRejected), 16'(d[i] < 3 || d[i] > 97));
         cyc(450);
         measure;
         chk(16'(hi), 16'(e[i]));
         chk(16'(per), 16'd200);
         chk(16'(highLevelOffer), 16'(d[i] == 5));
      end
      $display("duty test done");
   endtask
   task t_trig;
      chk(16'(adcSingleEnded), 16'h1);
      for (int i = 0; i < 400 && midOnAdcTrigger !== 1'b1; i++) @(negedge clk);
      chk(16'(adcConvStart), 16'h1);
      cyc(1);
      chk(16'(midOnAdcTrigger), 16'h0);
      trigSelect = 2'h1;
      extTrigA = 1;
      #1 chk(16'(adcConvStart), 16'h1);
      cyc(1);
      extTrigA = 0;
      trigSelect = 2'h2;
      extTrigB = 1;
      #1 chk(16'(adcConvStart), 16'h1);
      cyc(1);
      extTrigB = 0;
      trigSelect = 2'h0;
      $display("trigger test done");
   endtask
   task t_stop;
      evLoad = 2'h1;
      wait_state(`CPPS_ST_B);
      cyc(450);
      chk(16'(charging), 16'h0);
      chk(16'(driveMode), 16'(`CPPS_MODE_HIGH));
      evLoad = 2'h3;
      wait_state(`CPPS_ST_D);
      cyc(450);
      chk(16'(pilotPwmDrive), 16'h1);
      evLoad = 2'h0;
      wait_state(`CPPS_ST_A);
      supplyFault = 1;
      cyc(450);
      chk(16'(pilotPwmDrive), 16'h0);
      wait_state(`CPPS_ST_E);
      chk(16'(charging), 16'h0);
      supplyFault = 0;
      wait_state(`CPPS_ST_A);
      $display("stop and fault test done");
   endtask
   // Main sequence
   initial begin
      cyc(2);
      rst = 0;
      t_charge;
      t_duty;
      t_trig;
      t_stop;
      final_report;
   end
endmodule // testbench
`default_nettype wire
